// ### hw/cpp_charger_map.vh
/*
 Constants for the charger and power path controller: register offsets,
 field positions, reset values, state codes and timing counts.
 Assumes a 25 MHz clock and a 32-bit AHB-Lite register bus.
*/
`ifndef CPP_CHARGER_MAP_VH
`define CPP_CHARGER_MAP_VH

// Register byte offsets
`define CPP_OFS_CTRL     8'h00
`define CPP_OFS_STATUS   8'h04
`define CPP_OFS_IRQ_STAT 8'h08
`define CPP_OFS_IRQ_MASK 8'h0c

// Control register fields
`define CPP_CTRL_EN_BIT  0
`define CPP_CTRL_RST     1'h0

// Interrupt status bits
`define CPP_IRQ_STATE    0
`define CPP_IRQ_FAULT    1
`define CPP_IRQ_INVALID  2
`define CPP_IRQ_W        3
`define CPP_MASK_RST     3'h0

// Charger states
`define CPP_ST_NOPWR     3'h0
`define CPP_ST_SUSP      3'h1
`define CPP_ST_DIS       3'h2
`define CPP_ST_PREQ      3'h3
`define CPP_ST_FAST      3'h4
`define CPP_ST_TOPOFF    3'h5
`define CPP_ST_DONE      3'h6
`define CPP_ST_FAULT     3'h7

// Input current limit codes in mA
`define CPP_ILIM_1000    10'h3e8
`define CPP_ILIM_475     10'h1db
`define CPP_ILIM_95      10'h05f
`define CPP_ILIM_0       10'h000

// Charge current command codes
`define CPP_ICMD_ZERO    2'h0
`define CPP_ICMD_TENTH   2'h1
`define CPP_ICMD_FULL    2'h2

// Timing: clock and times as printed
`define CPP_CLK_HZ       25000000
`define CPP_PREQ_MIN     33
`define CPP_FAST_MIN     660
`define CPP_TOPOFF_MIN   33
`define CPP_BLINK_HZ     2
`define CPP_DGL_CYC      4'h8
// Quarter-second tick: two ticks per 2 Hz period
`define CPP_TICK_CYC     24'h5f5e10
`define CPP_TICKS_PER_MIN (60 * `CPP_BLINK_HZ * 2)
// Timer limits in quarter-second ticks, sized to the 18-bit tick counter
`define CPP_PREQ_TICKS   18'h01ef0
`define CPP_FAST_TICKS   18'h26ac0
`define CPP_TOP_TICKS    18'h01ef0

`endif

// ### hw/cpp_charger_ctrl.v
/*
 Charger and input power path controller: select decode and deglitch,
 input qualification, load switch, charge state machine, safety timers,
 open-drain status output and an AHB-Lite register slave with interrupt.
 Assumes analog comparators give clean levels synchronous to clk.
*/
// Implementation choices: the register addresses and register access over AHB-Lite.
// Behaviour
// - Select code maps to limit or suspend
// - Deglitch both select inputs
// - Undervoltage input is invalid and disconnected
// - Input below battery is invalid
// - Overvoltage disconnects system rail from input
// - Load switch closed without valid input
// - Charge only when valid, unsuspended, enabled
// - Below 3.0V start prequalification, tenth current
// - Reaching 3.0V moves to full-current fast
// - Tenth current enters 33min top-off, done
// - Done restarts below regulation minus 100mV
// - Status low in prequal and fast charge
// - Timer expiry blinks status at 2Hz, held
// - Prequalification limited to 33 minutes
// - Fast charge limited to 660 minutes
// - Reduced current slows the charge timer
// - 20 to 50 percent runs half rate
// - Code 11 suspends from any state
`timescale 1ns/1ps
`include "cpp_charger_map.vh"

module cpp_charger_ctrl #(
	parameter [23:0] TICK_CYC = `CPP_TICK_CYC  // Shorten for simulation
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Host lines
	input  wire        limitSelectHi,
	input  wire        limitSelectLo,
	input  wire        chargerEnableIn,
	output reg         chargeStatusOut,
	output reg         chargeStatusOe_n,
	// Comparators
	input  wire        inputUnderVolt,
	input  wire        inputBelowBattery,
	input  wire        inputOverVolt,
	input  wire        batteryBelowPrequal,
	input  wire        batteryBelowRecharge,
	input  wire        currentBelowTenth,
	input  wire        currentBelowHalf,
	input  wire        currentBelowFifth,
	input  wire        constantVoltageMode,
	// Power path controls
	output reg  [9:0]  inputLimitMa,
	output reg         inputSwitchOn,
	output reg         loadSwitchOn,
	output reg  [1:0]  chargeCurrentCmd,
	output reg         irq,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp
);

	// Deglitch state
	reg  [1:0]  selStable_ff;   // Accepted select code
	reg  [1:0]  selLast_ff;     // Last raw sample
	reg  [3:0]  dglCnt_ff;      // Stability count
	// Charger state and timers
	reg  [2:0]  state_ff;       // Charger state
	reg  [2:0]  nxt_state;
	reg  [23:0] preCnt_ff;      // Prescaler cycles
	reg         halfPhase_ff;   // Alternates ticks for half rate
	reg  [17:0] tickCnt_ff;     // Quarter-second ticks in state; 18 bits hold 660 min
	reg         blink_ff;       // 2 Hz square wave
	// Registers
	reg         ctrlEn_ff;      // Software charge enable
	reg  [2:0]  irqStat_ff;     // Sticky events
	reg  [2:0]  irqMask_ff;     // Event masks
	// Bus data phase
	reg         wrPend_ff;
	reg  [7:0]  wrAddr_ff;

	wire [1:0]  selRaw = {limitSelectHi, limitSelectLo};
	wire        suspend = (selStable_ff == 2'h3);
	// Input valid: above undervoltage and above battery
	wire        inValid = !inputUnderVolt && !inputBelowBattery;
	wire        chgEn = chargerEnableIn && ctrlEn_ff;
	wire        tick = (preCnt_ff == TICK_CYC - 24'h1);
	wire [17:0] preqLim = `CPP_PREQ_TICKS;
	wire [17:0] fastLim = `CPP_FAST_TICKS;
	wire [17:0] topLim = `CPP_TOP_TICKS;
	// Timer slowing only in constant-current fast charge, below half, above a fifth
	wire        slowRate = (state_ff == `CPP_ST_FAST) && !constantVoltageMode
		&& currentBelowHalf && !currentBelowFifth;
	wire        timerStep = tick && (!slowRate || halfPhase_ff);
	wire        stateChg = (nxt_state != state_ff);

	// Select deglitch: code accepted after it holds steady
	always @(posedge clk) begin
		if (rst) begin
			selStable_ff <= 2'h0;
			selLast_ff <= 2'h0;
			dglCnt_ff <= 4'h0;
		end else begin
			selLast_ff <= selRaw;
			if (selRaw != selLast_ff) begin
				dglCnt_ff <= 4'h0;
			end else if (dglCnt_ff == `CPP_DGL_CYC) begin
				selStable_ff <= selLast_ff;
			end else begin
				dglCnt_ff <= dglCnt_ff + 4'h1;
			end
		end
	end

	// Charger next state
	always @* begin
		nxt_state = state_ff;
		if (!inValid) begin
			nxt_state = `CPP_ST_NOPWR;
		end else if (suspend) begin
			nxt_state = `CPP_ST_SUSP;
		end else if (!chgEn) begin
			nxt_state = `CPP_ST_DIS;
		end else begin
			case (state_ff)
				`CPP_ST_NOPWR, `CPP_ST_SUSP, `CPP_ST_DIS: begin
					// Cycle starts by sensing the battery
					nxt_state = batteryBelowPrequal ? `CPP_ST_PREQ
						: `CPP_ST_FAST;
				end
				`CPP_ST_PREQ: begin
					if (!batteryBelowPrequal)
						nxt_state = `CPP_ST_FAST;
					else if (tickCnt_ff >= preqLim)
						nxt_state = `CPP_ST_FAULT;
				end
				`CPP_ST_FAST: begin
					if (currentBelowTenth)
						nxt_state = `CPP_ST_TOPOFF;
					else if (tickCnt_ff >= fastLim)
						nxt_state = `CPP_ST_FAULT;
				end
				`CPP_ST_TOPOFF: begin
					if (tickCnt_ff >= topLim)
						nxt_state = `CPP_ST_DONE;
				end
				`CPP_ST_DONE: begin
					if (batteryBelowRecharge)
						nxt_state = `CPP_ST_FAST;
				end
				`CPP_ST_FAULT: begin
					nxt_state = `CPP_ST_FAULT;
				end
				default: begin
					nxt_state = `CPP_ST_NOPWR;
				end
			endcase
		end
	end

	// State, prescaler and timers; every change except one out of fault clears them
	always @(posedge clk) begin
		if (rst) begin
			state_ff <= `CPP_ST_NOPWR;
			preCnt_ff <= 24'h0;
			halfPhase_ff <= 1'b0;
			tickCnt_ff <= 18'h0;
			blink_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (stateChg && state_ff != `CPP_ST_FAULT) begin
				preCnt_ff <= 24'h0;
				halfPhase_ff <= 1'b0;
				tickCnt_ff <= 18'h0;
			end else begin
				preCnt_ff <= tick ? 24'h0 : preCnt_ff + 24'h1;
				if (tick) begin
					halfPhase_ff <= !halfPhase_ff;
					blink_ff <= !blink_ff;
				end
				// Saturate so a held count never wraps
				if (timerStep && tickCnt_ff != 18'h3ffff)
					tickCnt_ff <= tickCnt_ff + 18'h1;
			end
		end
	end

	// Registered power path and status outputs
	always @(posedge clk) begin
		if (rst) begin
			inputLimitMa <= `CPP_ILIM_1000;
			inputSwitchOn <= 1'b0;
			loadSwitchOn <= 1'b1;
			chargeCurrentCmd <= `CPP_ICMD_ZERO;
			chargeStatusOut <= 1'b0;
			chargeStatusOe_n <= 1'b1;
		end else begin
			case (selStable_ff)
				2'h0: inputLimitMa <= `CPP_ILIM_1000;
				2'h1: inputLimitMa <= `CPP_ILIM_475;
				2'h2: inputLimitMa <= `CPP_ILIM_95;
				default: inputLimitMa <= `CPP_ILIM_0;
			endcase
			// Overvoltage only opens the input path; load switch stays open while input is valid
			inputSwitchOn <= inValid && !inputOverVolt && !suspend;
			loadSwitchOn <= !inValid;
			case (state_ff)
				`CPP_ST_PREQ: chargeCurrentCmd <= `CPP_ICMD_TENTH;
				`CPP_ST_FAST: chargeCurrentCmd <= `CPP_ICMD_FULL;
				`CPP_ST_TOPOFF: chargeCurrentCmd <= `CPP_ICMD_TENTH;
				default: chargeCurrentCmd <= `CPP_ICMD_ZERO;
			endcase
			// Open drain: enable low pulls the pin low
			chargeStatusOut <= 1'b0;
			case (state_ff)
				`CPP_ST_PREQ, `CPP_ST_FAST: chargeStatusOe_n <= 1'b0;
				`CPP_ST_FAULT: chargeStatusOe_n <= blink_ff;
				default: chargeStatusOe_n <= 1'b1;
			endcase
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY
	wire addrPh = hsel && hready && htrans[1];
	always @(posedge clk) begin
		if (rst) begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 8'h0;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ctrlEn_ff <= `CPP_CTRL_RST;
			irqMask_ff <= `CPP_MASK_RST;
			irqStat_ff <= 3'h0;
			irq <= 1'b0;
		end else begin
			wrPend_ff <= addrPh && hwrite;
			wrAddr_ff <= haddr[7:0];
			// Read data readied in the data phase
			if (addrPh && !hwrite) begin
				case (haddr[7:0])
					`CPP_OFS_CTRL: hrdata <= {31'h0, ctrlEn_ff};
					`CPP_OFS_STATUS: hrdata <= {17'h0, inputLimitMa,
						inValid, suspend, state_ff};
					`CPP_OFS_IRQ_STAT: hrdata <= {29'h0, irqStat_ff};
					`CPP_OFS_IRQ_MASK: hrdata <= {29'h0, irqMask_ff};
					default: hrdata <= 32'h0;             // Unmapped reads zero
				endcase
			end
			if (wrPend_ff && wrAddr_ff == `CPP_OFS_CTRL)
				ctrlEn_ff <= hwdata[`CPP_CTRL_EN_BIT];
			if (wrPend_ff && wrAddr_ff == `CPP_OFS_IRQ_MASK)
				irqMask_ff <= hwdata[`CPP_IRQ_W-1:0];
			// Set wins over a write-one clear in the same cycle
			irqStat_ff <= (irqStat_ff & ~((wrPend_ff && wrAddr_ff == `CPP_OFS_IRQ_STAT)
				? hwdata[`CPP_IRQ_W-1:0] : 3'h0))
				| {!inValid && state_ff != `CPP_ST_NOPWR,
				nxt_state == `CPP_ST_FAULT && state_ff != `CPP_ST_FAULT,
				stateChg};
			irq <= |(irqStat_ff & irqMask_ff);
		end
	end

endmodule // cpp_charger_ctrl

// ### dv/cpp_charger_checker.sv
/* Port checker for the charger controller.
 Bound to cpp_charger_ctrl; one clock, synchronous reset. */
`timescale 1ns/1ps
`include "cpp_charger_map.vh"
module cpp_charger_checker (
	// Clock and reset
	input wire       clk,
	input wire       rst,
	// Host lines and comparators
	input wire       limitSelectHi,
	input wire       limitSelectLo,
	input wire       chargerEnableIn,
	input wire       inputUnderVolt,
	input wire       inputBelowBattery,
	input wire       inputOverVolt,
	// Outputs watched
	input wire       chargeStatusOe_n,
	input wire [9:0] inputLimitMa,
	input wire       inputSwitchOn,
	input wire       loadSwitchOn,
	input wire [1:0] chargeCurrentCmd
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire [1:0] sel = {limitSelectHi, limitSelectLo}; // Raw select code
	wire       bad = inputUnderVolt | inputBelowBattery; // Input unusable
	wire [9:0] want = sel == 2'h0 ? 10'h3e8 : sel == 2'h1 ? 10'h1db :
		sel == 2'h2 ? 10'h05f : 10'h000; // Limit each code should give
	// Long steady code leaves the deglitcher settled
	a_limit_map: assert property ($stable(sel)[*8] ##1 $stable(sel)[*8] |-> inputLimitMa == want)
		else $error("limit differs from select code");
	a_select_deglitch: assert property ($changed(sel) |=> $stable(inputLimitMa)[*6])
		else $error("limit moved before select settled");
	a_invalid_off: assert property (bad[*3] |-> !inputSwitchOn && loadSwitchOn)
		else $error("invalid input still connected");
	a_overvolt_off: assert property (inputOverVolt[*3] |-> !inputSwitchOn)
		else $error("overvoltage input still connected");
	a_switch_excl: assert property (inputSwitchOn |-> !loadSwitchOn)
		else $error("both switches closed");
	a_disable_zero: assert property (!chargerEnableIn[*3] |-> chargeCurrentCmd == `CPP_ICMD_ZERO)
		else $error("charging while disabled");
	a_fast_status: assert property (chargeCurrentCmd == `CPP_ICMD_FULL |-> !chargeStatusOe_n)
		else $error("status released in fast charge");
	a_suspend_zero: assert property ((inputLimitMa == `CPP_ILIM_0)[*3] |->
		chargeCurrentCmd == `CPP_ICMD_ZERO && chargeStatusOe_n)
		else $error("suspend still charging");
	// Main scenarios reached
	c_prequal: cover property (chargeCurrentCmd == `CPP_ICMD_TENTH);
	c_fast: cover property (chargeCurrentCmd == `CPP_ICMD_FULL);
	c_suspend: cover property (inputLimitMa == `CPP_ILIM_0);
endmodule // cpp_charger_checker

bind cpp_charger_ctrl cpp_charger_checker cpp_charger_checker_inst (.clk, .rst, .limitSelectHi,
	.limitSelectLo, .chargerEnableIn, .inputUnderVolt, .inputBelowBattery, .inputOverVolt,
	.chargeStatusOe_n, .inputLimitMa, .inputSwitchOn, .loadSwitchOn, .chargeCurrentCmd);

// ### dv/cpp_host_model.sv
/* Host processor model: drives enable and select lines, pulls up status.
 Assumes bench requests and the controller share one clock. */
`timescale 1ns/1ps
module cpp_host_model (
	// Clock and bench requests
	input wire        clk,
	input wire        enReq,
	input wire  [1:0] selReq,
	// Charger lines
	input wire        chargeStatusOut,
	input wire        chargeStatusOe_n,
	output logic      chargerEnableIn,
	output logic      limitSelectHi,
	output logic      limitSelectLo,
	output wire       statusLine
);
	// Released pin reads the pull-up level, not the old value
	assign statusLine = chargeStatusOe_n ? 1'b1 : chargeStatusOut;
	initial {chargerEnableIn, limitSelectHi, limitSelectLo} = 3'h0;
	// Host moves its lines just after the edge
	always @(posedge clk) begin
		chargerEnableIn <= enReq;
		{limitSelectHi, limitSelectLo} <= selReq;
	end
endmodule // cpp_host_model

// ### dv/cpp_charger_ctrl_bench.sv
/* Bench for the charger controller: bus tasks, host model, comparators.
 Assumes a zero-wait bus slave and a short tick parameter. */
`timescale 1ns/1ps
`include "cpp_charger_map.vh"
module cpp_charger_ctrl_bench;
	localparam int TICK = 2; // Short tick keeps timer tests brief
	localparam int SPAN = 7920 * TICK + 8; // 33 minutes of ticks plus slack
	logic clk = 1'b0, rst = 1'b1, enReq = 1'b0, hsel = 1'b0, hwrite = 1'b0, prev;
	logic inputUnderVolt = 1'b0, inputBelowBattery = 1'b0, inputOverVolt = 1'b0;
	logic batteryBelowPrequal = 1'b0, batteryBelowRecharge = 1'b0, currentBelowTenth = 1'b0;
	logic currentBelowHalf = 1'b0, currentBelowFifth = 1'b0, constantVoltageMode = 1'b0;
	logic [1:0] selReq = 2'h0, htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	wire chargerEnableIn, limitSelectHi, limitSelectLo, chargeStatusOut, chargeStatusOe_n;
	wire statusLine, inputSwitchOn, loadSwitchOn, irq, hreadyout, hresp;
	wire [9:0] inputLimitMa;
	wire [1:0] chargeCurrentCmd;
	wire [31:0] hrdata;
	int fails = 0, samples_checked = 0, cycles = 0, n;
	always #20 clk = ~clk;
	cpp_host_model cpp_host_model_inst (.clk, .enReq, .selReq, .chargeStatusOut,
		.chargeStatusOe_n, .chargerEnableIn, .limitSelectHi, .limitSelectLo, .statusLine);
	cpp_charger_ctrl #(.TICK_CYC(24'h2)) cpp_charger_ctrl_inst (.clk, .rst, .limitSelectHi,
		.limitSelectLo, .chargerEnableIn, .chargeStatusOut, .chargeStatusOe_n, .inputUnderVolt,
		.inputBelowBattery, .inputOverVolt, .batteryBelowPrequal, .batteryBelowRecharge,
		.currentBelowTenth, .currentBelowHalf, .currentBelowFifth, .constantVoltageMode,
		.inputLimitMa, .inputSwitchOn, .loadSwitchOn, .chargeCurrentCmd, .irq, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One single word transfer; waits on ready, never on a fixed count
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1; // Look at outputs once the edge has settled them
	endtask
	task automatic st(input logic [2:0] s);
		bus(1'b0, 32'h4, 32'h0);
		chk({29'h0, rd[2:0]}, {29'h0, s});
	endtask
	task automatic note(input string s);
		$display("test %s finished", s);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		cyc(2);
		rst <= 1'b0;
		chk({22'h0, inputLimitMa}, 32'h3e8);
		chk({27'h0, statusLine, loadSwitchOn, inputSwitchOn, chargeCurrentCmd}, 32'h18);
		cyc(4);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h0);
		st(3'h2);
		bus(1'b0, 32'h8, 32'h0);
		chk(rd & 32'h1, 32'h1);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 32'hc, 32'h7);
		cyc(2);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, 32'h8, 32'h7);
		cyc(2);
		chk({31'h0, irq}, 32'h0);
		bus(1'b0, 32'h40, 32'h0);
		chk(rd, 32'h0);
		note("registers");
		// Every select code, then a glitch through suspend
		for (n = 0; n < 4; n++) begin
			selReq <= n[1:0];
			cyc(20);
			chk({22'h0, inputLimitMa}, n == 0 ? 32'h3e8 : n == 1 ? 32'h1db : n == 2 ? 32'h5f : 0);
		end
		st(3'h1);
		selReq <= 2'h1;
		cyc(20);
		selReq <= 2'h3;
		cyc(3);
		selReq <= 2'h2;
		cyc(6);
		chk({22'h0, inputLimitMa}, 32'h1db);
		st(3'h2);
		cyc(20);
		chk({22'h0, inputLimitMa}, 32'h5f);
		selReq <= 2'h0;
		cyc(20);
		note("limits");
		for (n = 0; n < 3; n++) begin
			{inputOverVolt, inputBelowBattery, inputUnderVolt} <= 3'h1 << n;
			cyc(4);
			chk({31'h0, inputSwitchOn}, 32'h0);
			{inputOverVolt, inputBelowBattery, inputUnderVolt} <= 3'h0;
			cyc(4);
			chk({30'h0, inputSwitchOn, loadSwitchOn}, 32'h2);
		end
		note("input");
		bus(1'b1, 32'h0, 32'h1);
		batteryBelowPrequal <= 1'b1;
		enReq <= 1'b1;
		cyc(5);
		chk({29'h0, statusLine, chargeCurrentCmd}, 32'h1);
		batteryBelowPrequal <= 1'b0;
		cyc(4);
		chk({29'h0, statusLine, chargeCurrentCmd}, 32'h2);
		currentBelowTenth <= 1'b1;
		cyc(4);
		st(3'h5);
		chk({31'h0, statusLine}, 32'h1);
		cyc(SPAN - 20);
		st(3'h5);
		cyc(16);
		st(3'h6);
		chk({29'h0, statusLine, chargeCurrentCmd}, 32'h4);
		currentBelowTenth <= 1'b0;
		batteryBelowRecharge <= 1'b1;
		cyc(4);
		st(3'h4);
		batteryBelowRecharge <= 1'b0;
		note("charge");
		enReq <= 1'b0;
		batteryBelowPrequal <= 1'b1;
		cyc(4);
		st(3'h2);
		enReq <= 1'b1;
		cyc(SPAN);
		st(3'h7);
		chk({30'h0, chargeCurrentCmd}, 32'h0);
		n = 0;
		// Blink period is two ticks, so each tick must show one edge
		repeat (8 * TICK) begin
			prev = statusLine;
			@(posedge clk);
			n += (statusLine !== prev);
		end
		chk(n, 32'h8);
		bus(1'b0, 32'h8, 32'h0);
		chk(rd & 32'h2, 32'h2);
		enReq <= 1'b0;
		cyc(4);
		st(3'h2);
		chk({31'h0, statusLine}, 32'h1);
		note("fault");
		wrap_up();
	end
endmodule // cpp_charger_ctrl_bench
